// file: rtl/trace_trigger_status.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// How it works
// (R1) sticky a/b/c hit flags, status bits 7..5
// (R2) status bit 0 mirrors arm while enabled
// (R3) end-run reset, if enabled and begin trigger clear, clears arm, keeps flags
// (R4) count bits 3..0, binary zero to eight
// (R5) count saturates at eight
// (R6) arming clears count, capture increments
// (R7) host reads count words, count never decrements
// (R8) end-run reset, if enabled and begin trigger clear, keeps the count
// (R9) nothing operates unless unit enabled
// (R10) comparator a matches address bus
// (R11) comparator b uses data in full modes
// (R12) comparator c matches address, hits forwarded outside loop mode
// (R13) full modes: write only if a-en and a-sel 0
// (R14) full modes ignore b rw bits
// (R15) loop mode: c tracks last capture
// (R16) arm in loop mode clears c
// (R17) equal flow address suppresses capture
// (R18) different address captured, loaded into c
// (R19) c ext bit 7 takes paged marker
// (R20) full modes are codes 0101 and 0110
// (R21) arming clears three hit flags
// (R22) trigger/full clears the arm bit only
// (R23) status and count ignore writes
module trace_trigger_status #(
   parameter int ADDR_W = 17
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic end_run_reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic [ADDR_W-1:0] core_addr,
   input wire logic [7:0] core_read_data,
   input wire logic [7:0] core_write_data,
   input wire logic core_write,
   input wire logic core_valid,
   input wire logic trigger_event,
   input wire logic flow_change_event,
   input wire logic [ADDR_W-1:0] flow_change_addr,
   input wire logic paged_access_indicator,
   output logic compare_a_hit,
   output logic compare_b_hit,
   output logic compare_c_hit,
   output logic fifo_capture,
   output logic [ADDR_W:0] fifo_capture_word
);
   logic [7:0] debug_control_reg;
   logic [7:0] debug_trigger_reg;
   logic [7:0] rw_qual_reg;
   logic [7:0] cmp_a_extended_value, cmp_a_high_value, cmp_a_low_value;
   logic [7:0] cmp_b_extended_value, cmp_b_high_value, cmp_b_low_value;
   logic [7:0] cmp_c_extended_value, cmp_c_high_value, cmp_c_low_value;
   logic compare_a_hit_flag, compare_b_hit_flag, compare_c_hit_flag;
   logic [3:0] fifo_valid_words;
   logic end_run_clear;
   logic [ADDR_W:0] next_capture_word;

   function automatic logic [ADDR_W-1:0] cmp_value(input logic [7:0] ext,
                                                   input logic [7:0] high,
                                                   input logic [7:0] low);
      cmp_value = ADDR_W'({ext[0], high, low});
   endfunction : cmp_value

   wire debug_unit_enable = debug_control_reg[trace_status_pkg::CTL_ENABLE_BIT];
   wire arm_bit = debug_control_reg[trace_status_pkg::CTL_ARM_BIT];
   wire dedupe_capture_mode = debug_control_reg[trace_status_pkg::CTL_LOOP_BIT];
   wire begin_trigger = debug_trigger_reg[trace_status_pkg::TRG_BEGIN_BIT];
   wire [3:0] trigger_mode_code = debug_trigger_reg[trace_status_pkg::TRG_MODE_MSB:0];
   wire active = debug_unit_enable && arm_bit; // R9
   wire full_mode = (trigger_mode_code == trace_status_pkg::MODE_A_AND_B) ||
                    (trigger_mode_code == trace_status_pkg::MODE_A_AND_NOT_B); // R20
   wire cmp_a_rw_qualify_enable = rw_qual_reg[trace_status_pkg::RWQ_A_EN_BIT];
   wire cmp_a_rw_select = rw_qual_reg[trace_status_pkg::RWQ_A_SEL_BIT];
   wire cmp_b_rw_qualify_enable = rw_qual_reg[trace_status_pkg::RWQ_B_EN_BIT];
   wire cmp_b_rw_select = rw_qual_reg[trace_status_pkg::RWQ_B_SEL_BIT];
   // full modes: write compare only on a-en=1, a-sel=0, else read bus
   wire full_write = cmp_a_rw_qualify_enable && !cmp_a_rw_select; // R13
   wire [7:0] full_data = full_write ? core_write_data : core_read_data; // R13
   wire full_dir_ok = (core_write == full_write); // R13
   // b's rw bits are replaced by a's in full modes
   wire b_rw_en = full_mode ? 1'b0 : cmp_b_rw_qualify_enable; // R14
   wire a_rw_en = full_mode ? 1'b0 : cmp_a_rw_qualify_enable;

   logic raw_a, raw_b, raw_c;
   addr_comparator #(.ADDR_W(ADDR_W)) u_cmp_a (
      .value(cmp_value(cmp_a_extended_value, cmp_a_high_value, cmp_a_low_value)),
      .bus_addr(core_addr),
      .bus_data(8'h00),
      .data_value(8'h00),
      .data_mode(1'b0),
      .bus_write(core_write),
      .rw_enable(a_rw_en),
      .rw_select(cmp_a_rw_select),
      .hit(raw_a)
   ); // R10
   addr_comparator #(.ADDR_W(ADDR_W)) u_cmp_b (
      .value(cmp_value(cmp_b_extended_value, cmp_b_high_value, cmp_b_low_value)),
      .bus_addr(core_addr),
      .bus_data(full_data),
      .data_value(cmp_b_low_value),
      .data_mode(full_mode),
      .bus_write(core_write),
      .rw_enable(b_rw_en),
      .rw_select(cmp_b_rw_select),
      .hit(raw_b)
   ); // R11
   addr_comparator #(.ADDR_W(ADDR_W)) u_cmp_c (
      .value(cmp_value(cmp_c_extended_value, cmp_c_high_value, cmp_c_low_value)),
      .bus_addr(core_addr),
      .bus_data(8'h00),
      .data_value(8'h00),
      .data_mode(1'b0),
      .bus_write(core_write),
      .rw_enable(1'b0),
      .rw_select(1'b0),
      .hit(raw_c)
   ); // R12

   wire match_a = core_valid && debug_unit_enable && raw_a && (!full_mode || full_dir_ok);
   wire match_b = core_valid && debug_unit_enable && raw_b && (!full_mode || full_dir_ok);
   // c is not a breakpoint in loop capture mode
   wire match_c = core_valid && debug_unit_enable && raw_c && !dedupe_capture_mode; // R15

   // loop duplicate check against the last captured flow address
   wire [ADDR_W-1:0] last_flow = cmp_value(cmp_c_extended_value, cmp_c_high_value,
                                           cmp_c_low_value);
   wire flow_dup = dedupe_capture_mode && (flow_change_addr == last_flow); // R17
   wire do_capture = active && flow_change_event && !flow_dup; // R9 R17 R18
   wire arm_write = reg_write && (reg_addr == trace_status_pkg::ADDR_CONTROL) &&
                    reg_wdata[trace_status_pkg::CTL_ENABLE_BIT] &&
                    reg_wdata[trace_status_pkg::CTL_ARM_BIT];
   wire stop_run = active && ((!begin_trigger && trigger_event) ||
                   (begin_trigger && fifo_valid_words == trace_status_pkg::COUNT_FULL &&
                    flow_change_event)); // R22
   assign end_run_clear = end_run_reset && debug_unit_enable && !begin_trigger;

   // control and trigger registers
   always_ff @(posedge ref_clk) begin
      if (srst && end_run_clear) begin
         debug_control_reg[trace_status_pkg::CTL_ARM_BIT] <= 1'b0; // R3
         debug_control_reg[4] <= 1'b0;
      end else if (srst) begin
         debug_control_reg <= trace_status_pkg::RESET_CONTROL;
         debug_trigger_reg <= trace_status_pkg::RESET_TRIGGER;
         rw_qual_reg <= 8'h00;
      end else begin
         if (reg_write && reg_addr == trace_status_pkg::ADDR_CONTROL) begin
            debug_control_reg <= reg_wdata;
         end else if (stop_run) begin
            debug_control_reg[trace_status_pkg::CTL_ARM_BIT] <= 1'b0; // R22
         end
         // trigger setup is locked while armed
         if (reg_write && reg_addr == trace_status_pkg::ADDR_TRIGGER && !arm_bit) begin
            debug_trigger_reg <= reg_wdata;
         end
         if (reg_write && reg_addr == trace_status_pkg::ADDR_RW_QUAL) begin
            rw_qual_reg <= reg_wdata;
         end
      end
   end

   // comparator a and b value registers
   always_ff @(posedge ref_clk) begin
      if (srst && !end_run_clear) begin
         cmp_a_extended_value <= 8'h00;
         cmp_a_high_value <= 8'h00;
         cmp_a_low_value <= 8'h00;
         cmp_b_extended_value <= 8'h00;
         cmp_b_high_value <= 8'h00;
         cmp_b_low_value <= 8'h00;
      end else if (!srst && reg_write) begin
         unique case (reg_addr)
            trace_status_pkg::ADDR_CMP_A_EXT: cmp_a_extended_value <= reg_wdata;
            trace_status_pkg::ADDR_CMP_A_HIGH: cmp_a_high_value <= reg_wdata;
            trace_status_pkg::ADDR_CMP_A_LOW: cmp_a_low_value <= reg_wdata;
            trace_status_pkg::ADDR_CMP_B_EXT: cmp_b_extended_value <= reg_wdata;
            trace_status_pkg::ADDR_CMP_B_HIGH: cmp_b_high_value <= reg_wdata;
            trace_status_pkg::ADDR_CMP_B_LOW: cmp_b_low_value <= reg_wdata;
            default: ;
         endcase
      end
   end

   // comparator c: software owned, or tracker in loop capture mode
   always_ff @(posedge ref_clk) begin
      if (srst && !end_run_clear) begin
         cmp_c_extended_value <= 8'h00;
         cmp_c_high_value <= 8'h00;
         cmp_c_low_value <= 8'h00;
      end else if (!srst) begin
         if (arm_write && reg_wdata[trace_status_pkg::CTL_LOOP_BIT]) begin
            cmp_c_extended_value <= 8'h00; // R16
            cmp_c_high_value <= 8'h00; // R16
            cmp_c_low_value <= 8'h00; // R16
         end else if (do_capture && dedupe_capture_mode) begin
            cmp_c_extended_value <= {paged_access_indicator, 6'h00,
                                     flow_change_addr[ADDR_W-1]}; // R18 R19
            cmp_c_high_value <= flow_change_addr[15:8]; // R18
            cmp_c_low_value <= flow_change_addr[7:0]; // R18
         end else if (reg_write && !dedupe_capture_mode) begin
            // software writes are ignored in loop mode
            if (reg_addr == trace_status_pkg::ADDR_CMP_C_EXT) cmp_c_extended_value <= reg_wdata;
            if (reg_addr == trace_status_pkg::ADDR_CMP_C_HIGH) cmp_c_high_value <= reg_wdata;
            if (reg_addr == trace_status_pkg::ADDR_CMP_C_LOW) cmp_c_low_value <= reg_wdata;
         end
      end
   end

   // sticky hit flags; set wins over arming clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         if (!end_run_clear) begin
            compare_a_hit_flag <= 1'b0;
            compare_b_hit_flag <= 1'b0;
            compare_c_hit_flag <= 1'b0;
         end // R3
      end else begin
         compare_a_hit_flag <= match_a || (compare_a_hit_flag && !arm_write); // R1 R21
         compare_b_hit_flag <= match_b || (compare_b_hit_flag && !arm_write); // R1 R21
         compare_c_hit_flag <= match_c || (compare_c_hit_flag && !arm_write); // R1 R21
      end
   end

   // capture count: never decremented by fifo reads
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         if (!end_run_clear) fifo_valid_words <= 4'h0; // R8
      end else if (arm_write) begin
         fifo_valid_words <= 4'h0; // R6
      end else if (do_capture && fifo_valid_words != trace_status_pkg::COUNT_FULL) begin
         fifo_valid_words <= fifo_valid_words + 4'h1; // R5 R6
      end
   end

   // registered outputs toward the controller and fifo
   assign next_capture_word = {paged_access_indicator, flow_change_addr};
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         compare_a_hit <= 1'b0;
         compare_b_hit <= 1'b0;
         compare_c_hit <= 1'b0;
         fifo_capture <= 1'b0;
         fifo_capture_word <= '0;
      end else begin
         compare_a_hit <= match_a; // R10
         compare_b_hit <= match_b; // R11
         compare_c_hit <= match_c; // R12
         fifo_capture <= do_capture; // R17 R18
         if (do_capture) fifo_capture_word <= next_capture_word;
      end
   end

   // read port; status and count have no write path
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            trace_status_pkg::ADDR_CMP_A_EXT: reg_rdata <= cmp_a_extended_value;
            trace_status_pkg::ADDR_CMP_A_HIGH: reg_rdata <= cmp_a_high_value;
            trace_status_pkg::ADDR_CMP_A_LOW: reg_rdata <= cmp_a_low_value;
            trace_status_pkg::ADDR_CMP_B_EXT: reg_rdata <= cmp_b_extended_value;
            trace_status_pkg::ADDR_CMP_B_HIGH: reg_rdata <= cmp_b_high_value;
            trace_status_pkg::ADDR_CMP_B_LOW: reg_rdata <= cmp_b_low_value;
            trace_status_pkg::ADDR_CMP_C_EXT: reg_rdata <= cmp_c_extended_value;
            trace_status_pkg::ADDR_CMP_C_HIGH: reg_rdata <= cmp_c_high_value;
            trace_status_pkg::ADDR_CMP_C_LOW: reg_rdata <= cmp_c_low_value;
            trace_status_pkg::ADDR_CONTROL: reg_rdata <= debug_control_reg;
            trace_status_pkg::ADDR_TRIGGER: reg_rdata <= debug_trigger_reg;
            trace_status_pkg::ADDR_STATUS: reg_rdata <= {compare_a_hit_flag,
               compare_b_hit_flag, compare_c_hit_flag, 4'h0, active}; // R1 R2 R23
            trace_status_pkg::ADDR_COUNT: reg_rdata <= {4'h0, fifo_valid_words}; // R4 R23
            trace_status_pkg::ADDR_RW_QUAL: reg_rdata <= rw_qual_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   AST_ARM_MIRROR: assert property (@(posedge ref_clk) disable iff (srst)
      reg_read && reg_addr == trace_status_pkg::ADDR_STATUS |=>
      reg_rdata[0] == $past(debug_unit_enable && arm_bit))
      else $error("status bit 0 not arm image"); // R2
   AST_COUNT_MAX: assert property (@(posedge ref_clk) disable iff (srst)
      fifo_valid_words <= trace_status_pkg::COUNT_FULL)
      else $error("capture count above eight"); // R5
   AST_COUNT_CLR: assert property (@(posedge ref_clk) disable iff (srst)
      arm_write |=> fifo_valid_words == 4'h0)
      else $error("arming did not clear count"); // R6
   AST_COUNT_INC: assert property (@(posedge ref_clk) disable iff (srst)
      !arm_write && do_capture && fifo_valid_words < 4'h8 |=>
      fifo_valid_words == $past(fifo_valid_words) + 4'h1)
      else $error("count did not advance"); // R6
   AST_ENDRUN_KEEP: assert property (@(posedge ref_clk)
      srst && end_run_clear |=> $stable(fifo_valid_words) && $stable(compare_a_hit_flag))
      else $error("end-run reset changed count or flags"); // R8 R3
   AST_IDLE: assert property (@(posedge ref_clk) disable iff (srst)
      !debug_unit_enable |=> !fifo_capture && !compare_a_hit)
      else $error("activity while disabled"); // R9
   AST_DUP: assert property (@(posedge ref_clk) disable iff (srst)
      active && flow_change_event && flow_dup |=> !fifo_capture)
      else $error("duplicate captured"); // R17
   AST_STICKY_A: assert property (@(posedge ref_clk) disable iff (srst)
      match_a |=> compare_a_hit_flag)
      else $error("a flag not set"); // R1
   AST_ARM_CLR: assert property (@(posedge ref_clk) disable iff (srst)
      stop_run && !reg_write |=> !arm_bit)
      else $error("arm not cleared at trigger"); // R22
endmodule : trace_trigger_status

// file: common/trace_status_pkg.sv
package trace_status_pkg;
   localparam logic [7:0] ADDR_CMP_A_EXT = 8'h00;
   localparam logic [7:0] ADDR_CMP_A_HIGH = 8'h01;
   localparam logic [7:0] ADDR_CMP_A_LOW = 8'h02;
   localparam logic [7:0] ADDR_CMP_B_EXT = 8'h03;
   localparam logic [7:0] ADDR_CMP_B_HIGH = 8'h04;
   localparam logic [7:0] ADDR_CMP_B_LOW = 8'h05;
   localparam logic [7:0] ADDR_CMP_C_EXT = 8'h06;
   localparam logic [7:0] ADDR_CMP_C_HIGH = 8'h07;
   localparam logic [7:0] ADDR_CMP_C_LOW = 8'h08;
   localparam logic [7:0] ADDR_CONTROL = 8'h0c;
   localparam logic [7:0] ADDR_TRIGGER = 8'h0d;
   localparam logic [7:0] ADDR_STATUS = 8'h0e;
   localparam logic [7:0] ADDR_COUNT = 8'h0f;
   localparam logic [7:0] ADDR_RW_QUAL = 8'h10;
   localparam logic [7:0] ADDR_CAPTURE_LOW = 8'h11;
   localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h12;
   localparam logic [7:0] ADDR_CAPTURE_EXT = 8'h13;
   // control register fields
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_ARM_BIT = 6;
   localparam int CTL_LOOP_BIT = 0;
   // trigger register fields
   localparam int TRG_BEGIN_BIT = 6;
   localparam int TRG_MODE_MSB = 3;
   // status fields
   localparam int STS_A_BIT = 7;
   localparam int STS_B_BIT = 6;
   localparam int STS_C_BIT = 5;
   localparam int STS_ARM_BIT = 0;
   // read/write qualify register fields
   localparam int RWQ_A_EN_BIT = 3;
   localparam int RWQ_A_SEL_BIT = 2;
   localparam int RWQ_B_EN_BIT = 1;
   localparam int RWQ_B_SEL_BIT = 0;
   localparam int PAGED_MARK_BIT = 7;
   localparam logic [3:0] MODE_A_AND_B = 4'h5;
   localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
   localparam logic [7:0] RESET_CONTROL = 8'hc0;
   localparam logic [7:0] RESET_TRIGGER = 8'h00;
   localparam logic [7:0] RESET_STATUS = 8'h01;
   localparam logic [7:0] RESET_COUNT = 8'h00;
   localparam logic [3:0] COUNT_FULL = 4'h8;
endpackage : trace_status_pkg

// file: rtl/addr_comparator.sv
`timescale 1ns/1ps
module addr_comparator #(
   parameter int ADDR_W = 17
) (
   input wire logic [ADDR_W-1:0] value,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_data,
   input wire logic [7:0] data_value,
   input wire logic data_mode,
   input wire logic bus_write,
   input wire logic rw_enable,
   input wire logic rw_select,
   output logic hit
);
   logic base_hit;
   logic rw_ok;
   always_comb begin
      base_hit = data_mode ? (bus_data == data_value) : (bus_addr == value);
      // rw_select 1 means read, 0 means write
      rw_ok = !rw_enable || (rw_select == !bus_write);
      hit = base_hit && rw_ok;
   end
endmodule : addr_comparator

// file: tb/core_bus_model.sv
`timescale 1ns/1ps
module core_bus_model #(
   parameter int ADDR_W = 17
) (
   input wire logic ref_clk,
   output logic [ADDR_W-1:0] core_addr,
   output logic [7:0] core_read_data,
   output logic [7:0] core_write_data,
   output logic core_write,
   output logic core_valid,
   output logic flow_change_event,
   output logic [ADDR_W-1:0] flow_change_addr,
   output logic paged_access_indicator
);
   initial begin
      core_addr = '0;
      core_read_data = 8'h00;
      core_write_data = 8'h00;
      core_write = 1'b0;
      core_valid = 1'b0;
      flow_change_event = 1'b0;
      flow_change_addr = '0;
      paged_access_indicator = 1'b0;
   end
   // idle lines show the inverse so a stale value can never pass for a match
   task automatic bus_cycle(input logic [ADDR_W-1:0] a, input logic [7:0] rd,
                            input logic [7:0] wd, input logic wr);
      @(posedge ref_clk);
      core_addr <= a;
      core_read_data <= rd;
      core_write_data <= wd;
      core_write <= wr;
      core_valid <= 1'b1;
      @(posedge ref_clk);
      core_valid <= 1'b0;
      core_addr <= ~a;
      core_read_data <= ~rd;
      core_write_data <= ~wd;
      core_write <= ~wr;
      #1;
   endtask : bus_cycle
   task automatic flow(input logic [ADDR_W-1:0] a, input logic pg);
      @(posedge ref_clk);
      flow_change_addr <= a;
      paged_access_indicator <= pg;
      flow_change_event <= 1'b1;
      @(posedge ref_clk);
      flow_change_event <= 1'b0;
      flow_change_addr <= ~a;
      paged_access_indicator <= ~pg;
      #1;
   endtask : flow
endmodule : core_bus_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic ref_clk, srst, end_run_reset, reg_write, reg_read, core_write, core_valid;
   logic trigger_event, flow_change_event, paged_access_indicator, fifo_capture;
   logic compare_a_hit, compare_b_hit, compare_c_hit;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, core_read_data, core_write_data;
   logic [16:0] core_addr, flow_change_addr;
   logic [17:0] fifo_capture_word;
   int miscompares = 0;
   int checked = 0;
   logic [16:0] hit_addr [3] = '{17'h12345, 17'h00abc, 17'h10f0f};
   logic [3:0] full_mode [2] = '{trace_status_pkg::MODE_A_AND_B,
                                 trace_status_pkg::MODE_A_AND_NOT_B};
   trace_trigger_status u_trace_trigger_status (.ref_clk(ref_clk), .srst(srst),
      .end_run_reset(end_run_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .core_addr(core_addr), .core_read_data(core_read_data),
      .core_write_data(core_write_data), .core_write(core_write), .core_valid(core_valid),
      .trigger_event(trigger_event), .flow_change_event(flow_change_event),
      .flow_change_addr(flow_change_addr), .paged_access_indicator(paged_access_indicator),
      .compare_a_hit(compare_a_hit), .compare_b_hit(compare_b_hit),
      .compare_c_hit(compare_c_hit), .fifo_capture(fifo_capture),
      .fifo_capture_word(fifo_capture_word));
   core_bus_model u_core_bus_model (.ref_clk(ref_clk), .core_addr(core_addr),
      .core_read_data(core_read_data), .core_write_data(core_write_data),
      .core_write(core_write), .core_valid(core_valid), .flow_change_event(flow_change_event),
      .flow_change_addr(flow_change_addr), .paged_access_indicator(paged_access_indicator));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask : reg_wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      check(32'(reg_rdata), 32'(exp));
   endtask : rd_chk
   task automatic pulse_reset(input logic end_run);
      @(posedge ref_clk);
      srst <= 1'b1;
      end_run_reset <= end_run;
      @(posedge ref_clk);
      srst <= 1'b0;
      end_run_reset <= 1'b0;
   endtask : pulse_reset
   initial begin
      repeat (20000) @(posedge ref_clk);
      $display("timeout");
      miscompares++;
      final_report();
   end
   initial begin
      srst = 1'b1;
      end_run_reset = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      trigger_event = 1'b0;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      rd_chk(trace_status_pkg::ADDR_STATUS, 8'h01);
      rd_chk(trace_status_pkg::ADDR_COUNT, 8'h00);
      reg_wr(trace_status_pkg::ADDR_STATUS, 8'hfe);
      reg_wr(trace_status_pkg::ADDR_COUNT, 8'hff);
      rd_chk(trace_status_pkg::ADDR_STATUS, 8'h01);
      rd_chk(trace_status_pkg::ADDR_COUNT, 8'h00);
      rd_chk(trace_status_pkg::ADDR_CAPTURE_LOW, 8'h00);
      $display("test reset_values done");
      for (int i = 0; i < 3; i++) begin
         reg_wr(8'(3 * i), {7'h00, hit_addr[i][16]});
         reg_wr(8'(3 * i + 1), hit_addr[i][15:8]);
         reg_wr(8'(3 * i + 2), hit_addr[i][7:0]);
      end
      for (int i = 0; i < 3; i++) begin
         u_core_bus_model.bus_cycle(hit_addr[i], 8'h00, 8'h00, 1'b0);
         check({compare_a_hit, compare_b_hit, compare_c_hit}, 3'b100 >> i);
      end
      u_core_bus_model.bus_cycle(17'h12344, 8'h00, 8'h00, 1'b0);
      check({compare_a_hit, compare_b_hit, compare_c_hit}, 3'b000);
      rd_chk(trace_status_pkg::ADDR_STATUS, 8'he1);
      $display("test comparators done");
      // disarm first; any write with enable and arm set counts as arming
      reg_wr(trace_status_pkg::ADDR_CONTROL, 8'h80);
      reg_wr(trace_status_pkg::ADDR_CONTROL, 8'hc1);
      rd_chk(trace_status_pkg::ADDR_STATUS, 8'h01);
      rd_chk(trace_status_pkg::ADDR_COUNT, 8'h00);
      rd_chk(trace_status_pkg::ADDR_CMP_C_LOW, 8'h00);
      u_core_bus_model.flow(17'h10100, 1'b1);
      check(fifo_capture_word, {1'b1, 17'h10100});
      rd_chk(trace_status_pkg::ADDR_CMP_C_EXT, 8'h81);
      rd_chk(trace_status_pkg::ADDR_CMP_C_HIGH, 8'h01);
      rd_chk(trace_status_pkg::ADDR_CMP_C_LOW, 8'h00);
      u_core_bus_model.flow(17'h10100, 1'b1);
      check(fifo_capture, 1'b0);
      rd_chk(trace_status_pkg::ADDR_COUNT, 8'h01);
      for (int i = 0; i < 9; i++) begin
         u_core_bus_model.flow(17'h00300 + 17'(i), 1'b0);
         check(fifo_capture, 1'b1);
         rd_chk(trace_status_pkg::ADDR_COUNT, (i + 2 > 8) ? 8'h08 : 8'(i + 2));
      end
      // c now holds the last captured address; in loop mode it must not hit
      u_core_bus_model.bus_cycle(17'h00308, 8'h00, 8'h00, 1'b0);
      check(compare_c_hit, 1'b0);
      u_core_bus_model.bus_cycle(17'h12345, 8'h00, 8'h00, 1'b0);
      rd_chk(trace_status_pkg::ADDR_STATUS, 8'h81);
      $display("test loop_capture done");
      pulse_reset(1'b1);
      rd_chk(trace_status_pkg::ADDR_STATUS, 8'h80);
      rd_chk(trace_status_pkg::ADDR_COUNT, 8'h08);
      rd_chk(trace_status_pkg::ADDR_COUNT, 8'h08);
      $display("test end_run_reset done");
      reg_wr(trace_status_pkg::ADDR_CONTROL, 8'hc0);
      rd_chk(trace_status_pkg::ADDR_STATUS, 8'h01);
      rd_chk(trace_status_pkg::ADDR_COUNT, 8'h00);
      @(posedge ref_clk);
      trigger_event <= 1'b1;
      @(posedge ref_clk);
      trigger_event <= 1'b0;
      rd_chk(trace_status_pkg::ADDR_STATUS, 8'h00);
      $display("test trigger done");
      for (int m = 0; m < 2; m++) begin
         reg_wr(trace_status_pkg::ADDR_TRIGGER, {4'h0, full_mode[m]});
         // b rw bits set to the opposite sense to show they are ignored
         reg_wr(trace_status_pkg::ADDR_RW_QUAL, 8'h0b);
         u_core_bus_model.bus_cycle(17'h00001, 8'h00, 8'hbc, 1'b1);
         check(compare_b_hit, 1'b1);
         u_core_bus_model.bus_cycle(17'h00001, 8'hbc, 8'h00, 1'b0);
         check(compare_b_hit, 1'b0);
         reg_wr(trace_status_pkg::ADDR_RW_QUAL, 8'h0c);
         u_core_bus_model.bus_cycle(17'h00001, 8'hbc, 8'h00, 1'b0);
         check(compare_b_hit, 1'b1);
         u_core_bus_model.bus_cycle(17'h00001, 8'h00, 8'hbc, 1'b1);
         check(compare_b_hit, 1'b0);
      end
      $display("test full_mode done");
      // arm left set with enable clear, so only the enable gate stops capture
      reg_wr(trace_status_pkg::ADDR_CONTROL, 8'h41);
      u_core_bus_model.flow(17'h05555, 1'b0);
      check(fifo_capture, 1'b0);
      rd_chk(trace_status_pkg::ADDR_COUNT, 8'h00);
      $display("test disabled done");
      final_report();
   end
endmodule : tb
